// *** hw/tcm_regs.svh ***
// register indices, field positions, reset values and timing figures of the timer
`ifndef TCM_REGS_SVH
`define TCM_REGS_SVH

// register indices; byte address is four times the index
`define TCM_IDX_CMP_LO     6'h10
`define TCM_IDX_CMP_HI     6'h11
`define TCM_IDX_CAP_LO     6'h12
`define TCM_IDX_CAP_HI     6'h13
`define TCM_IDX_CTL        6'h14
`define TCM_IDX_SYSCFG     6'h15
`define TCM_IDX_COUNT      6'h16
`define TCM_IDX_NONE       6'h3f

// reset values
`define TCM_RST_TREG       16'hffff
`define TCM_RST_CTL        8'h00
`define TCM_RST_SYSCFG     2'h0

// run field codes
`define TCM_RUN_STOP       2'h0
`define TCM_RUN_CMD        2'h1
`define TCM_RUN_FALL       2'h3

// source clock codes
`define TCM_CK_SLOW        2'h0
`define TCM_CK_DIV7        2'h1
`define TCM_CK_DIV3        2'h2
`define TCM_CK_PIN         2'h3

// syscfg field positions
`define TCM_SYS_TAP        0
`define TCM_SYS_LOWSPEED   1

// prescaler widths: fc/2^11, fc/2^7, fc/2^3 and fs/2^3
`define TCM_PRESC_W        11
`define TCM_DIV7_W         7
`define TCM_DIV3_W         3
`define TCM_FSDIV_W        3

`endif

// *** hw/tcm_pkg.sv ***
// types shared by the timer counter block
package tcm_pkg;

    // operating mode field
    typedef enum logic [1:0] {
        TCM_MODE_TIMER  = 2'h0,
        TCM_MODE_WINDOW = 2'h1,
        TCM_MODE_PULSE  = 2'h2,
        TCM_MODE_PPG    = 2'h3
    } tcm_mode_e;

    // control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic      output_flipflop_init;
        logic      auto_capture_enable;
        logic [1:0] run_edge_control;
        logic [1:0] source_clock_select;
        tcm_mode_e operating_mode_select;
    } tcm_ctl_s;

    // whole state of the timer
    typedef struct packed {
        tcm_ctl_s    ctl;
        logic [1:0]  sys_cfg;
        logic [15:0] cmp_act;
        logic [7:0]  cmp_lo;
        logic [7:0]  cmp_hi;
        logic        cmp_pend;
        logic [15:0] cap_act;
        logic [7:0]  cap_lo;
        logic [7:0]  cap_hi;
        logic        cap_pend;
        logic [15:0] cnt;
        logic        match;
        logic [10:0] presc;
        logic [1:0]  lf_sync;
        logic        lf_prev;
        logic [2:0]  lf_div;
        logic [1:0]  pin_sync;
        logic        pin_prev;
        logic        dp_wr;
        logic [5:0]  dp_idx;
        logic [31:0] rdata;
    } tcm_state_s;

endpackage : tcm_pkg

// *** hw/tcm_timer.sv ***
// 16-bit timer counter with AHB-Lite register slave, timer mode and auto-capture
// Operation
// RL1: counter and timer registers 16 bits, byte access
// RL2: stop code halts and zeroes the counter
// RL3: capture register writable only in pulse-output mode
// RL4: command start counts at once in timer mode
// RL5: edge setting picks start or counting edge; code counts only on command start, falling code picks pin edge
// RL6: codes select fc/128, fc/8 or the pin
// RL7: code 00 gives fc/2048 or fs/8
// RL8: mode field picks timer, window, pulse, pulse-output
// RL9: upper byte write loads value at next tick
// RL10: software writes lower byte then upper byte
// RL11: software changes setup only while stopped
// RL12: software sets flip-flop state before first start
// RL13: auto-capture only in timer, event, window modes; the code captures in timer mode only
// RL14: software keeps compare above one
// RL15: software keeps flip-flop bit zero outside pulse-output
// RL16: software writes second register after pulse-output selected
// RL17: stop power entry forces run field to stop
// RL18: software reads capture only while capture runs
// RL19: capture copies each tick; first read waits
// RL20: match raises interrupt, clears counter, resumes
// RL21: timer mode capture copies the running counter
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "tcm_regs.svh"

module tcm_timer (
    // clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        SYS_RST,
    // ahb-lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // external pins, asynchronous
    input  wire logic        COUNT_INPUT_PIN,
    input  wire logic        LOW_FREQ_CLK,
    // power controller, same clock
    input  wire logic        STOP_ENTRY,
    // event output
    output logic             MATCH_INTERRUPT
);

    ////////////////////////////////////////////////////////////////////////////
    // state and decoded helpers

    tcm_pkg::tcm_state_s st_reg;   // all registered state
    tcm_pkg::tcm_state_s st_next;  // next value of the state

    logic        running;          // timer mode, command start
    logic        src_tick;         // one cycle per source clock edge
    logic        pin_edge;         // selected edge of the count pin
    logic        lf_rise;          // rising edge of the low-frequency clock
    logic        addr_ok;          // address phase accepted
    logic        mapped;           // address lands on a register
    logic        cap_copy;         // auto-capture takes the counter this tick
    logic [5:0]  wr_idx;           // register being written in data phase
    logic        wr_en;            // data phase of a write
    logic [7:0]  wr_byte;          // written byte, low lane

    assign running = (st_reg.ctl.run_edge_control == `TCM_RUN_CMD) &&
                     (st_reg.ctl.operating_mode_select == tcm_pkg::TCM_MODE_TIMER); // RL4 RL8
    assign lf_rise  = st_reg.lf_sync[1] & ~st_reg.lf_prev;
    assign addr_ok  = HSEL & HTRANS[1] & HREADY;
    assign mapped   = (HADDR[31:8] == 24'h000000) && (HADDR[1:0] == 2'h0) &&
                      (HADDR[7:2] >= `TCM_IDX_CMP_LO) && (HADDR[7:2] <= `TCM_IDX_COUNT);
    assign wr_en    = st_reg.dp_wr;
    assign wr_idx   = st_reg.dp_idx;
    assign wr_byte  = HWDATA[7:0];
    // capture runs only in timer mode while counting; running already excludes window mode
    assign cap_copy = src_tick && running && st_reg.ctl.auto_capture_enable &&
                      ((st_reg.ctl.operating_mode_select == tcm_pkg::TCM_MODE_TIMER) ||
                       (st_reg.ctl.operating_mode_select == tcm_pkg::TCM_MODE_WINDOW)); // RL13

    ////////////////////////////////////////////////////////////////////////////
    // source clock selection

    // rising edge unless the run field asks for the falling one
    always_comb begin
        if (st_reg.ctl.run_edge_control == `TCM_RUN_FALL) begin
            pin_edge = ~st_reg.pin_sync[1] & st_reg.pin_prev; // RL5
        end else begin
            pin_edge = st_reg.pin_sync[1] & ~st_reg.pin_prev; // RL5
        end
    end

    // fast taps are not available when the core runs on the slow clock
    always_comb begin
        case (st_reg.ctl.source_clock_select)
            `TCM_CK_SLOW: begin
                if (st_reg.sys_cfg[`TCM_SYS_TAP] || st_reg.sys_cfg[`TCM_SYS_LOWSPEED]) begin
                    src_tick = lf_rise && (st_reg.lf_div == 3'h7); // RL7
                end else begin
                    src_tick = &st_reg.presc; // RL7
                end
            end
            `TCM_CK_DIV7: begin
                src_tick = (&st_reg.presc[`TCM_DIV7_W-1:0]) &&
                           !st_reg.sys_cfg[`TCM_SYS_LOWSPEED]; // RL6
            end
            `TCM_CK_DIV3: begin
                src_tick = (&st_reg.presc[`TCM_DIV3_W-1:0]) &&
                           !st_reg.sys_cfg[`TCM_SYS_LOWSPEED]; // RL6
            end
            default: begin
                src_tick = pin_edge; // RL6
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    // order matters: tick loads use the old pending flags, so a buffer
    // write in the same cycle as a tick waits for the following tick
    always_comb begin
        st_next = st_reg;
        // prescaler and synchronisers; first stages feed only second stages
        st_next.presc    = st_reg.presc + 11'h001;
        st_next.lf_sync  = {st_reg.lf_sync[0], LOW_FREQ_CLK};
        st_next.lf_prev  = st_reg.lf_sync[1];
        st_next.pin_sync = {st_reg.pin_sync[0], COUNT_INPUT_PIN};
        st_next.pin_prev = st_reg.pin_sync[1];
        if (lf_rise) begin
            st_next.lf_div = st_reg.lf_div + 3'h1;
        end
        st_next.match = 1'b0;
        // double-buffered timer registers load on the source tick
        if (src_tick && st_reg.cmp_pend) begin
            st_next.cmp_act  = {st_reg.cmp_hi, st_reg.cmp_lo}; // RL9 RL1
            st_next.cmp_pend = 1'b0;
        end
        if (src_tick && st_reg.cap_pend) begin
            st_next.cap_act  = {st_reg.cap_hi, st_reg.cap_lo}; // RL9 RL1
            st_next.cap_pend = 1'b0;
        end
        // counting
        if (st_reg.ctl.run_edge_control == `TCM_RUN_STOP) begin
            st_next.cnt = 16'h0000; // RL2
        end else if (running && src_tick) begin
            if (st_reg.cnt == st_reg.cmp_act) begin
                st_next.cnt   = 16'h0000; // RL20
                st_next.match = 1'b1;     // RL20
            end else begin
                st_next.cnt = st_reg.cnt + 16'h0001; // RL20
            end
        end
        // capture copies the counter as it stood at the tick
        if (cap_copy) begin
            st_next.cap_act = st_reg.cnt; // RL21 RL19
        end
        // data phase of a register write
        if (wr_en) begin
            case (wr_idx)
                `TCM_IDX_CMP_LO: begin
                    st_next.cmp_lo = wr_byte; // RL9
                end
                `TCM_IDX_CMP_HI: begin
                    st_next.cmp_hi   = wr_byte;
                    st_next.cmp_pend = 1'b1; // RL9
                end
                `TCM_IDX_CAP_LO: begin
                    if (st_reg.ctl.operating_mode_select == tcm_pkg::TCM_MODE_PPG) begin
                        st_next.cap_lo = wr_byte; // RL3
                    end
                end
                `TCM_IDX_CAP_HI: begin
                    if (st_reg.ctl.operating_mode_select == tcm_pkg::TCM_MODE_PPG) begin
                        st_next.cap_hi   = wr_byte; // RL3
                        st_next.cap_pend = 1'b1;
                    end
                end
                `TCM_IDX_CTL: begin
                    st_next.ctl = tcm_pkg::tcm_ctl_s'(wr_byte); // RL8
                end
                `TCM_IDX_SYSCFG: begin
                    st_next.sys_cfg = wr_byte[1:0];
                end
                default: begin
                    st_next.sys_cfg = st_next.sys_cfg; // read-only or unmapped
                end
            endcase
        end
        // stop power entry overrides a software start in the same cycle
        if (STOP_ENTRY) begin
            st_next.ctl.run_edge_control = `TCM_RUN_STOP; // RL17
        end
        // bus phase tracking
        st_next.dp_wr  = addr_ok && HWRITE && mapped && (HSIZE == 3'h2);
        st_next.dp_idx = mapped ? HADDR[7:2] : `TCM_IDX_NONE;
        if (!addr_ok) begin
            st_next.dp_idx = `TCM_IDX_NONE;
        end
        // read data comes from the state after this cycle's write,
        // so a read right behind a control or syscfg write sees the new value
        if (addr_ok && !HWRITE) begin
            case (mapped ? HADDR[7:2] : `TCM_IDX_NONE)
                `TCM_IDX_CMP_LO: st_next.rdata = {24'h000000, st_next.cmp_act[7:0]};
                `TCM_IDX_CMP_HI: st_next.rdata = {24'h000000, st_next.cmp_act[15:8]};
                `TCM_IDX_CAP_LO: st_next.rdata = {24'h000000, st_next.cap_act[7:0]};
                `TCM_IDX_CAP_HI: st_next.rdata = {24'h000000, st_next.cap_act[15:8]};
                `TCM_IDX_CTL:    st_next.rdata = {24'h000000, st_next.ctl};
                `TCM_IDX_SYSCFG: st_next.rdata = {30'h00000000, st_next.sys_cfg};
                `TCM_IDX_COUNT:  st_next.rdata = {16'h0000, st_next.cnt};
                default:         st_next.rdata = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    // synchronous reset to constants only
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            st_reg          <= '0;
            st_reg.ctl      <= tcm_pkg::tcm_ctl_s'(`TCM_RST_CTL);
            st_reg.sys_cfg  <= `TCM_RST_SYSCFG;
            st_reg.cmp_act  <= `TCM_RST_TREG;
            st_reg.cmp_lo   <= 8'hff;
            st_reg.cmp_hi   <= 8'hff;
            st_reg.cap_act  <= `TCM_RST_TREG;
            st_reg.cap_lo   <= 8'hff;
            st_reg.cap_hi   <= 8'hff;
            st_reg.dp_idx   <= `TCM_IDX_NONE;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // zero-wait slave, always OKAY
    assign HREADYOUT       = 1'b1;
    assign HRESP           = 1'b0;
    assign HRDATA          = st_reg.rdata;
    assign MATCH_INTERRUPT = st_reg.match;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking tcm_cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);

    // upper byte write, then the loading tick
    sequence cmp_upper_wr_s;
        wr_en && (wr_idx == `TCM_IDX_CMP_HI) && !src_tick;
    endsequence

    sequence cmp_load_tick_s;
        src_tick && st_reg.cmp_pend;
    endsequence

    // capture buffer load, unless auto-capture claims the register this tick
    sequence cap_load_tick_s;
        src_tick && st_reg.cap_pend && !cap_copy;
    endsequence

    stop_clears_a: assert property ( // RL2
        (st_reg.ctl.run_edge_control == `TCM_RUN_STOP) |=> (st_reg.cnt == 16'h0000))
        else $error("counter not zero while stopped");

    cap_wr_gate_a: assert property ( // RL3
        (wr_en && (wr_idx == `TCM_IDX_CAP_HI) &&
         (st_reg.ctl.operating_mode_select != tcm_pkg::TCM_MODE_PPG))
        |=> $stable(st_reg.cap_hi))
        else $error("capture register written outside pulse-output mode");

    count_step_a: assert property ( // RL4
        (running && src_tick && (st_reg.cnt != st_reg.cmp_act) && !STOP_ENTRY)
        |=> (st_reg.cnt == $past(st_reg.cnt) + 16'h0001))
        else $error("counter did not step on source tick");

    match_clear_a: assert property ( // RL20
        (running && src_tick && (st_reg.cnt == st_reg.cmp_act))
        |=> (st_reg.cnt == 16'h0000) && MATCH_INTERRUPT ##1 !MATCH_INTERRUPT)
        else $error("match did not clear counter or pulse interrupt");

    // an upper write arms the buffer; the next tick moves both bytes across
    upper_arm_a: assert property ( // RL9
        cmp_upper_wr_s |=> st_reg.cmp_pend)
        else $error("upper byte write did not arm the compare buffer");

    buf_load_a: assert property ( // RL9
        cmp_load_tick_s
        |=> (st_reg.cmp_act == {$past(st_reg.cmp_hi), $past(st_reg.cmp_lo)}))
        else $error("compare value not loaded at first tick after upper write");

    cap_load_a: assert property ( // RL9
        cap_load_tick_s
        |=> (st_reg.cap_act == {$past(st_reg.cap_hi), $past(st_reg.cap_lo)}))
        else $error("capture value not loaded at first tick after upper write");

    low_only_a: assert property ( // RL9
        (wr_en && (wr_idx == `TCM_IDX_CMP_LO) && !st_reg.cmp_pend)
        |=> $stable(st_reg.cmp_act))
        else $error("lower byte write changed active compare value");

    stop_entry_a: assert property ( // RL17
        STOP_ENTRY |=> (st_reg.ctl.run_edge_control == `TCM_RUN_STOP) ##1
                       (st_reg.cnt == 16'h0000))
        else $error("stop entry did not halt the timer");

    capture_copy_a: assert property ( // RL21
        cap_copy |=> (st_reg.cap_act == $past(st_reg.cnt)))
        else $error("auto-capture missed the counter value");

    no_capture_a: assert property ( // RL13
        ((st_reg.ctl.operating_mode_select == tcm_pkg::TCM_MODE_PULSE) && !st_reg.cap_pend)
        |=> $stable(st_reg.cap_act))
        else $error("capture moved in a mode without auto-capture");

    slow_taps_a: assert property ( // RL6
        (st_reg.sys_cfg[`TCM_SYS_LOWSPEED] &&
         ((st_reg.ctl.source_clock_select == `TCM_CK_DIV7) ||
          (st_reg.ctl.source_clock_select == `TCM_CK_DIV3))) |-> !src_tick)
        else $error("fast tap ticked in low-speed mode");

    fc_tap_a: assert property ( // RL7
        ((st_reg.ctl.source_clock_select == `TCM_CK_SLOW) && (st_reg.sys_cfg == 2'h0) &&
         src_tick) |=> (st_reg.presc == 11'h000))
        else $error("fc/2048 tick off its prescaler phase");

    // pin ticks follow the synchronised pin, on the edge the run field picks
    pin_fall_a: assert property ( // RL5
        ((st_reg.ctl.source_clock_select == `TCM_CK_PIN) &&
         (st_reg.ctl.run_edge_control == `TCM_RUN_FALL) && src_tick)
        |-> (!st_reg.pin_sync[1] && $past(st_reg.pin_sync[1])))
        else $error("pin tick not on a falling edge");

    pin_rise_a: assert property ( // RL5
        ((st_reg.ctl.source_clock_select == `TCM_CK_PIN) &&
         (st_reg.ctl.run_edge_control != `TCM_RUN_FALL) && src_tick)
        |-> (st_reg.pin_sync[1] && !$past(st_reg.pin_sync[1])))
        else $error("pin tick not on a rising edge");

endmodule : tcm_timer

// *** verification/tcm_pin_model.sv ***
// behavioural model of the external source that drives the count input pin
`timescale 1ns/10ps

module tcm_pin_model (
    // clock
    input  wire logic       clk,
    // request from the bench
    input  wire logic       start,
    input  wire logic [7:0] num_pulses,
    // pin and status
    output logic            pin,
    output logic            busy
);
    int unsigned left;   // pulses still to send
    int unsigned phase;  // cycle within one pulse

    initial begin
        pin = 1'b0;
        busy = 1'b0;
        left = 0;
        phase = 0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // four cycles high, four low: wide enough for the two-flop synchroniser
    always @(posedge clk) begin
        if (start && !busy) begin
            left <= num_pulses;
            phase <= 0;
            busy <= (num_pulses != 8'h00);
        end else if (busy) begin
            pin <= (phase < 4);
            phase <= (phase == 7) ? 0 : phase + 1;
            if (phase == 7) begin
                left <= left - 1;
                if (left == 1) begin
                    busy <= 1'b0;  // pin is left low, its idle level
                end
            end
        end
    end
endmodule : tcm_pin_model

// *** verification/tb_timer_counter_control_timer_mode.sv ***
// self-checking testbench for the timer counter over its register bus
`timescale 1ns/10ps
`include "tcm_regs.svh"

module tb_timer_counter_control_timer_mode;
    // clock, reset and bus
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    // far side and power controller
    logic        lf_clk = 1'b0;
    logic        stop_entry = 1'b0;
    logic        pin;
    logic        pin_start = 1'b0;
    logic        pin_busy;
    logic        match;
    // bookkeeping
    int          miscompares = 0;
    int          num_checks = 0;
    logic [15:0] v;
    logic [15:0] w;
    int          n;
    logic [7:0]  ctl_run [4] = '{8'h18, 8'h14, 8'h10, 8'h10};
    logic [1:0]  sys_cfg [4] = '{2'h0, 2'h0, 2'h0, 2'h1};
    int          exp_per [4] = '{32, 512, 8192, 320};

    always #5 clk = ~clk;
    // low-frequency clock, 100 ns period, phase unrelated to the core clock
    initial begin
        #3;
        forever #50 lf_clk = ~lf_clk;
    end

    tcm_timer DUT (
        .CORE_CLK(clk), .SYS_RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .COUNT_INPUT_PIN(pin), .LOW_FREQ_CLK(lf_clk), .STOP_ENTRY(stop_entry),
        .MATCH_INTERRUPT(match)
    );

    tcm_pin_model PIN (
        .clk(clk), .start(pin_start), .num_pulses(8'h05), .pin(pin), .busy(pin_busy)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // closing and comparisons
    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task chk16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk16

    task chk_cyc(input int got, input int exp);
        num_checks++;
        if (got != exp) begin
            miscompares++;
            $display("ERROR %0t period %0d expected %0d", $time, got, exp);
        end
    endtask : chk_cyc

    ////////////////////////////////////////////////////////////////////////////////
    // bus cycles: hold each phase until hready is seen high, bounded
    task wait_rdy;
        int t;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (hreadyout !== 1'b1 && t < 50);
        if (t >= 50) begin
            miscompares++;
            $display("ERROR %0t bus hang", $time);
        end
    endtask : wait_rdy

    task ahb_xfer(input logic [5:0] idx, input logic wr, input logic [7:0] d,
                  output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, idx, 2'b00};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy();
        q = hrdata;
        chk16({15'h0000, hresp}, 16'h0000);
    endtask : ahb_xfer

    task wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] q;
        ahb_xfer(idx, 1'b1, d, q);
    endtask : wr

    task rd(input logic [5:0] idx, output logic [15:0] r);
        logic [31:0] q;
        ahb_xfer(idx, 1'b0, 8'h00, q);
        r = q[15:0];
    endtask : rd

    // a byte pair, lower index first
    task rdp(input logic [5:0] idx, output logic [15:0] r);
        logic [15:0] lo;
        logic [15:0] hi;
        rd(idx, lo);
        rd(idx + 6'h01, hi);
        r = {hi[7:0], lo[7:0]};
    endtask : rdp

    // cycles between two match pulses
    task meas(output int c);
        int t;
        t = 0;
        while (match !== 1'b1 && t < 20000) begin
            @(posedge clk);
            t++;
        end
        @(posedge clk);
        c = 1;
        while (match !== 1'b1 && c < 20000) begin
            @(posedge clk);
            c++;
        end
    endtask : meas

    task end_test(input string s);
        $display("test %s done at %0t", s, $time);
    endtask : end_test

    // five pulses from the pin model, then time for the synchroniser
    task pulse_pin;
        pin_start <= 1'b1;
        @(posedge clk);
        pin_start <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pin_busy !== 1'b0 && n < 200);
        repeat (10) @(posedge clk);
    endtask : pulse_pin

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: the tests need about 19000 cycles
    initial begin
        #600us;
        miscompares++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // reset values, unmapped place reads zero
        rd(`TCM_IDX_CTL, v);    chk16(v, 16'h0000);
        rdp(`TCM_IDX_CMP_LO, v); chk16(v, 16'hffff);
        rdp(`TCM_IDX_CAP_LO, v); chk16(v, 16'hffff);
        rd(`TCM_IDX_COUNT, v);  chk16(v, 16'h0000);
        rd(`TCM_IDX_SYSCFG, v); chk16(v, 16'h0000);
        wr(`TCM_IDX_NONE, 8'h5a);
        rd(`TCM_IDX_NONE, v);   chk16(v, 16'h0000);
        end_test("reset");
        // refused capture write, then lower-byte-only compare write
        wr(`TCM_IDX_CTL, 8'h08);
        wr(`TCM_IDX_CAP_LO, 8'h55);
        wr(`TCM_IDX_CAP_HI, 8'h66);
        wr(`TCM_IDX_CMP_LO, 8'h03);
        repeat (20) @(posedge clk);
        rdp(`TCM_IDX_CAP_LO, v); chk16(v, 16'hffff);
        rdp(`TCM_IDX_CMP_LO, v); chk16(v, 16'hffff);
        wr(`TCM_IDX_CMP_HI, 8'h00);
        repeat (20) @(posedge clk);
        rdp(`TCM_IDX_CMP_LO, v); chk16(v, 16'h0003);
        end_test("buffering");
        // match period for every internal source clock, compare 3
        for (int i = 0; i < 4; i++) begin
            wr(`TCM_IDX_CTL, ctl_run[i] & 8'hcf);
            wr(`TCM_IDX_SYSCFG, {6'h00, sys_cfg[i]});
            wr(`TCM_IDX_CTL, ctl_run[i]);
            meas(n);
            chk_cyc(n, exp_per[i]);
            wr(`TCM_IDX_CTL, ctl_run[i] & 8'hcf);
        end
        wr(`TCM_IDX_CTL, 8'h08);
        wr(`TCM_IDX_SYSCFG, 8'h00);
        end_test("periods");
        // auto-capture follows the counter, then stop clears it
        wr(`TCM_IDX_CMP_LO, 8'hff);
        wr(`TCM_IDX_CMP_HI, 8'h00);
        wr(`TCM_IDX_CTL, 8'h58);
        repeat (40) @(posedge clk);
        rd(`TCM_IDX_CAP_LO, v);
        repeat (13) @(posedge clk);
        rd(`TCM_IDX_CAP_LO, w);
        chk16(w - v, 16'h0002);
        wr(`TCM_IDX_CTL, 8'h08);
        repeat (3) @(posedge clk);
        rd(`TCM_IDX_COUNT, v);  chk16(v, 16'h0000);
        end_test("capture");
        // stop power entry while running
        wr(`TCM_IDX_CTL, 8'h18);
        repeat (50) @(posedge clk);
        stop_entry <= 1'b1;
        @(posedge clk);
        stop_entry <= 1'b0;
        repeat (3) @(posedge clk);
        rd(`TCM_IDX_CTL, v);    chk16(v, 16'h0008);
        rd(`TCM_IDX_COUNT, v);  chk16(v, 16'h0000);
        end_test("stop entry");
        // the fc/8 code gives no ticks in low-speed mode
        wr(`TCM_IDX_SYSCFG, 8'h02);
        wr(`TCM_IDX_CTL, 8'h18);
        repeat (100) @(posedge clk);
        rd(`TCM_IDX_COUNT, v);  chk16(v, 16'h0000);
        wr(`TCM_IDX_CTL, 8'h08);
        wr(`TCM_IDX_SYSCFG, 8'h00);
        // pulse width mode does not count in this block
        wr(`TCM_IDX_CTL, 8'h0a);
        wr(`TCM_IDX_CTL, 8'h1a);
        repeat (40) @(posedge clk);
        rd(`TCM_IDX_COUNT, v);  chk16(v, 16'h0000);
        wr(`TCM_IDX_CTL, 8'h0a);
        end_test("low speed");
        // counting edges of the external pin, then loading on falling edges
        wr(`TCM_IDX_CTL, 8'h0c);
        wr(`TCM_IDX_CTL, 8'h1c);
        pulse_pin();
        rd(`TCM_IDX_COUNT, v);  chk16(v, 16'h0005);
        wr(`TCM_IDX_CTL, 8'h3c);
        wr(`TCM_IDX_CMP_LO, 8'h10);
        wr(`TCM_IDX_CMP_HI, 8'h00);
        rdp(`TCM_IDX_CMP_LO, v); chk16(v, 16'h00ff);
        pulse_pin();
        rdp(`TCM_IDX_CMP_LO, v); chk16(v, 16'h0010);
        rd(`TCM_IDX_COUNT, v);  chk16(v, 16'h0005);
        wr(`TCM_IDX_CTL, 8'h0c);
        end_test("pin");
        // capture register takes writes in pulse-output mode
        wr(`TCM_IDX_CTL, 8'h0b);
        wr(`TCM_IDX_CAP_LO, 8'h34);
        wr(`TCM_IDX_CAP_HI, 8'h12);
        repeat (20) @(posedge clk);
        rdp(`TCM_IDX_CAP_LO, v); chk16(v, 16'h1234);
        end_test("pulse output");
        give_verdict();
    end
endmodule : tb_timer_counter_control_timer_mode
